// ===== rtl/i2csp_pkg.sv
// constants, states and carrier types of the two-wire slave register port
//
// Operation
// [RQ1] slave only; never drives the clock line
// [RQ2] lines driven low only, released otherwise
// [RQ3] data set while clock low, sampled high
// [RQ4] start/stop detected from data edge, clock high
// [RQ5] abandon transfer after 25ms bus idle
// [RQ6] eight-bit bytes, each followed by acknowledge
// [RQ7] first byte: address plus direction; match acks
// [RQ8] address from select pin, sampled continuously
// [RQ9] acknowledge general call and its command byte
// [RQ10] general call 06h resets registers, powers down
// [RQ11] master code not acked; enter high-speed filtering
// [RQ12] leave high-speed mode at next stop
// [RQ13] standard and fast rates need no entry
// [RQ14] acknowledge pointer byte after write address
// [RQ15] two data bytes, high first, to pointer
// [RQ16] read sends high then low byte of pointer
// [RQ17] master nack, start or stop releases data
// [RQ18] start while busy is a repeated start
// [RQ19] pointer kept between transfers until rewritten
// [RQ20] stop, timeout or mismatch returns to idle
package i2csp_pkg;

	localparam logic [4:0]  ADDR_BASE      = 5'h12;
	localparam logic [6:0]  GCALL_ADDR     = 7'h00;
	localparam logic [7:0]  GCALL_RESET    = 8'h06;
	localparam logic [4:0]  HS_CODE_TOP    = 5'h01;
	localparam logic [1:0]  ADDR_SEL_GND   = 2'h0;
	localparam logic [1:0]  ADDR_SEL_VDD   = 2'h1;
	localparam logic [1:0]  ADDR_SEL_SDA   = 2'h2;
	localparam logic [1:0]  ADDR_SEL_SCL   = 2'h3;
	localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
	localparam logic [3:0]  TX_LAST_BIT    = 4'h7;
	localparam logic [2:0]  PTR_RESET      = 3'h0;
	localparam logic [15:0] WORD_RESET     = 16'h0000;
	localparam int          TIMEOUT_MS     = 25;
	localparam int          MCLK_HZ        = 50000000;
	localparam int          TIMEOUT_CYC    = TIMEOUT_MS * (MCLK_HZ / 1000);
	localparam int          TIMEOUT_W      = 21;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_RX    = 3'b001,
		ST_RXACK = 3'b010,
		ST_TX    = 3'b011,
		ST_TXACK = 3'b100
	} i2csp_state_t;

	// register write handed from the link to the core
	typedef struct packed {
		logic [2:0]  ptr;
		logic [15:0] data;
	} i2csp_wr_t;

	// event toggles and levels leaving the link domain
	typedef struct packed {
		logic wr;
		logic ptr;
		logic gc;
		logic req;
		logic act;
		logic hs;
		logic busy;
	} i2csp_ev_t;

endpackage

// ===== rtl/i2csp_sync.sv
// two-flop synchroniser for a group of levels or toggles
`timescale 1ns/1ns
module i2csp_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_r;
	logic [W-1:0] q_nxt;

	always_comb begin
		meta_nxt = d_i;
		q_nxt    = meta_r;
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_r <= '0;
			q_r    <= '0;
		end else begin
			meta_r <= meta_nxt;
			q_r    <= q_nxt;
		end
	end

	assign q_o = q_r;
endmodule

// ===== rtl/i2csp_timeout.sv
// idle watchdog: pulses once when busy without bus activity too long
`timescale 1ns/1ns
module i2csp_timeout #(
	parameter int LIMIT = i2csp_pkg::TIMEOUT_CYC
) (
	input  wire logic clk_i,
	input  wire logic resetn_i,
	input  wire logic busy_i,
	input  wire logic act_i,
	output logic      expire_o
);
	localparam logic [i2csp_pkg::TIMEOUT_W-1:0] LIM = i2csp_pkg::TIMEOUT_W'(LIMIT);

	logic [i2csp_pkg::TIMEOUT_W-1:0] cnt_r;
	logic [i2csp_pkg::TIMEOUT_W-1:0] cnt_nxt;
	logic                            exp_r;
	logic                            exp_nxt;

	always_comb begin
		cnt_nxt = cnt_r;
		exp_nxt = 1'b0;
		if (!busy_i || act_i) begin
			cnt_nxt = '0;
		end else if (cnt_r >= LIM) begin
			exp_nxt = 1'b1;                 // [RQ5]
			cnt_nxt = '0;
		end else begin
			cnt_nxt = cnt_r + 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_r <= '0;
			exp_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			exp_r <= exp_nxt;
		end
	end

	assign expire_o = exp_r;
endmodule

// ===== rtl/i2csp_top.sv
// two-wire slave register port: link-side bit engine and core-side handover
`timescale 1ns/1ns
module i2csp_top #(
	parameter int TIMEOUT_CYC = i2csp_pkg::TIMEOUT_CYC
) (
	input  wire logic        mclk_i,
	input  wire logic        resetn_i,
	input  wire logic        link_clk_i,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe_o,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o,
	input  wire logic        addr_pin_i,
	input  wire logic [15:0] rd_data_i,
	output logic      [2:0]  rd_ptr_o,
	output logic             wr_stb_o,
	output logic      [2:0]  wr_ptr_o,
	output logic      [15:0] wr_data_o,
	output logic             gc_reset_o,
	output logic             hs_mode_o
);
	// ---------------- link domain ----------------
	logic [2:0] pin_s;
	logic [1:0] back_s;
	logic       scl_s;
	logic       sda_s;
	logic       adp_s;

	// sampling on the free-running link clock covers 100k, 400k and hs rates alike [RQ13]
	i2csp_sync #(.W(3)) u_pin_sync (
		.clk_i    (link_clk_i),
		.resetn_i (resetn_i),
		.d_i      (~{scl_i, sda_i, addr_pin_i}),  // carried inverted: cleared flops read as idle-high lines
		.q_o      (pin_s)
	);
	assign scl_s = ~pin_s[2];
	assign sda_s = ~pin_s[1];
	assign adp_s = ~pin_s[0];

	logic                       abort_tg_r;
	logic                       snap_tg_r;
	logic [15:0]                snap_r;
	logic [2:0]                 ptr_m_r;

	i2csp_sync #(.W(2)) u_back_sync (
		.clk_i    (link_clk_i),
		.resetn_i (resetn_i),
		.d_i      ({abort_tg_r, snap_tg_r}),
		.q_o      (back_s)
	);

	i2csp_pkg::i2csp_state_t st_r, st_nxt;
	logic       scl_d_r, scl_d_nxt, sda_d_r, sda_d_nxt;
	logic [1:0] back_d_r, back_d_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic       first_r, first_nxt;
	logic       rw_r, rw_nxt;
	logic       gc_r, gc_nxt;
	logic [1:0] idx_r, idx_nxt;
	logic       txidx_r, txidx_nxt;
	logic [2:0] ptr_r, ptr_nxt;
	logic [7:0] hi_r, hi_nxt;
	logic [15:0] rdw_r, rdw_nxt;
	logic       oe_r, oe_nxt;
	logic       hs_r, hs_nxt;
	logic       never_lo_r, never_lo_nxt, never_hi_r, never_hi_nxt, eq_scl_r, eq_scl_nxt;
	i2csp_pkg::i2csp_wr_t wrw_r, wrw_nxt;
	i2csp_pkg::i2csp_ev_t ev_r, ev_nxt;

	logic       scl_rise, scl_fall, start_c, stop_c, abort_c, snap_c;
	logic [1:0] own_sel;
	logic       match, gcall, hscode;

	always_comb begin
		scl_rise = scl_s & ~scl_d_r;
		scl_fall = ~scl_s & scl_d_r;
		start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;          // [RQ4]
		stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;          // [RQ4]
		abort_c  = back_s[1] ^ back_d_r[1];
		snap_c   = back_s[0] ^ back_d_r[0];
		// pin tied to a fixed level never toggles; tied to scl it follows the clock [RQ8]
		if (never_hi_r)
			own_sel = i2csp_pkg::ADDR_SEL_GND;
		else if (never_lo_r)
			own_sel = i2csp_pkg::ADDR_SEL_VDD;
		else if (eq_scl_r)
			own_sel = i2csp_pkg::ADDR_SEL_SCL;
		else
			own_sel = i2csp_pkg::ADDR_SEL_SDA;
		match  = sh_r[7:1] == {i2csp_pkg::ADDR_BASE, own_sel};                 // [RQ7]
		gcall  = (sh_r[7:1] == i2csp_pkg::GCALL_ADDR) && !sh_r[0];             // [RQ9]
		hscode = sh_r[7:3] == i2csp_pkg::HS_CODE_TOP;                           // [RQ11]
	end

	always_comb begin
		st_nxt       = st_r;
		scl_d_nxt    = scl_s;
		sda_d_nxt    = sda_s;
		back_d_nxt   = back_s;
		cnt_nxt      = cnt_r;
		sh_nxt       = sh_r;
		first_nxt    = first_r;
		rw_nxt       = rw_r;
		gc_nxt       = gc_r;
		idx_nxt      = idx_r;
		txidx_nxt    = txidx_r;
		ptr_nxt      = ptr_r;
		hi_nxt       = hi_r;
		rdw_nxt      = snap_c ? snap_r : rdw_r;
		oe_nxt       = oe_r;
		hs_nxt       = hs_r;
		wrw_nxt      = wrw_r;
		ev_nxt       = ev_r;
		never_lo_nxt = never_lo_r & adp_s;
		never_hi_nxt = never_hi_r & ~adp_s;
		eq_scl_nxt   = eq_scl_r & (adp_s == scl_s);
		if (scl_rise || scl_fall)
			ev_nxt.act = ~ev_r.act;
		if (stop_c) begin
			st_nxt = i2csp_pkg::ST_IDLE;                        // [RQ20]
			oe_nxt = 1'b0;                                      // [RQ17]
			hs_nxt = 1'b0;                                      // [RQ12]
		end else if (start_c) begin
			// a start mid-transfer simply reopens the address phase [RQ18]
			st_nxt       = i2csp_pkg::ST_RX;
			cnt_nxt      = '0;
			first_nxt    = 1'b1;
			oe_nxt       = 1'b0;                                // [RQ17]
			never_lo_nxt = 1'b1;
			never_hi_nxt = 1'b1;
			eq_scl_nxt   = 1'b1;
			ev_nxt.req   = ~ev_r.req;
		end else if (abort_c) begin
			st_nxt = i2csp_pkg::ST_IDLE;                        // [RQ5] [RQ20]
			oe_nxt = 1'b0;
			hs_nxt = 1'b0;
		end else begin
			case (st_r)
				i2csp_pkg::ST_RX: begin
					if (scl_rise) begin
						sh_nxt  = {sh_r[6:0], sda_s};           // [RQ3] [RQ6]
						cnt_nxt = cnt_r + 4'h1;
					end else if (scl_fall && cnt_r == i2csp_pkg::BITS_PER_BYTE) begin
						st_nxt = i2csp_pkg::ST_IDLE;
						if (first_r) begin
							first_nxt = 1'b0;
							rw_nxt    = sh_r[0];
							gc_nxt    = gcall;
							idx_nxt   = '0;
							txidx_nxt = 1'b0;
							if (match || gcall) begin
								st_nxt = i2csp_pkg::ST_RXACK;   // [RQ7] [RQ9]
								oe_nxt = 1'b1;
							end else if (hscode) begin
								hs_nxt = 1'b1;                  // [RQ11]
							end
						end else if (gc_r) begin
							if (idx_r == 2'h0) begin
								st_nxt  = i2csp_pkg::ST_RXACK;  // [RQ9]
								oe_nxt  = 1'b1;
								idx_nxt = 2'h1;
								if (sh_r == i2csp_pkg::GCALL_RESET)
									ev_nxt.gc = ~ev_r.gc;       // [RQ10]
							end
						end else if (idx_r != 2'h3) begin
							st_nxt  = i2csp_pkg::ST_RXACK;      // [RQ14] [RQ15]
							oe_nxt  = 1'b1;
							idx_nxt = idx_r + 2'h1;
							if (idx_r == 2'h0) begin
								ptr_nxt    = sh_r[2:0];         // [RQ14] [RQ19]
								ev_nxt.ptr = ~ev_r.ptr;
							end else if (idx_r == 2'h1) begin
								hi_nxt = sh_r;                  // [RQ15]
							end else begin
								wrw_nxt   = '{ptr: ptr_r, data: {hi_r, sh_r}};
								ev_nxt.wr = ~ev_r.wr;           // [RQ15]
							end
						end
					end
				end
				i2csp_pkg::ST_RXACK: begin
					if (scl_fall) begin
						cnt_nxt = '0;
						if (rw_r) begin
							st_nxt = i2csp_pkg::ST_TX;          // [RQ16]
							sh_nxt = rdw_r[15:8];
							oe_nxt = ~rdw_r[15];                // [RQ2]
						end else begin
							st_nxt = i2csp_pkg::ST_RX;
							oe_nxt = 1'b0;
						end
					end
				end
				i2csp_pkg::ST_TX: begin
					if (scl_fall) begin
						if (cnt_r == i2csp_pkg::TX_LAST_BIT) begin
							st_nxt = i2csp_pkg::ST_TXACK;
							oe_nxt = 1'b0;
						end else begin
							sh_nxt  = {sh_r[6:0], 1'b1};        // [RQ3]
							cnt_nxt = cnt_r + 4'h1;
							oe_nxt  = ~sh_r[6];                 // [RQ2]
						end
					end
				end
				i2csp_pkg::ST_TXACK: begin
					if (scl_rise && (sda_s || txidx_r)) begin
						st_nxt = i2csp_pkg::ST_IDLE;            // [RQ17]
					end else if (scl_fall) begin
						st_nxt    = i2csp_pkg::ST_TX;           // [RQ16]
						txidx_nxt = 1'b1;
						cnt_nxt   = '0;
						sh_nxt    = rdw_r[7:0];
						oe_nxt    = ~rdw_r[7];
					end
				end
				default: begin
					st_nxt = i2csp_pkg::ST_IDLE;
					oe_nxt = 1'b0;
				end
			endcase
		end
		ev_nxt.hs   = hs_nxt;
		ev_nxt.busy = st_nxt != i2csp_pkg::ST_IDLE;
	end

	always_ff @(posedge link_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_r       <= i2csp_pkg::ST_IDLE;
			scl_d_r    <= 1'b1;
			sda_d_r    <= 1'b1;
			back_d_r   <= '0;
			cnt_r      <= '0;
			sh_r       <= '0;
			first_r    <= 1'b0;
			rw_r       <= 1'b0;
			gc_r       <= 1'b0;
			idx_r      <= '0;
			txidx_r    <= 1'b0;
			ptr_r      <= i2csp_pkg::PTR_RESET;
			hi_r       <= '0;
			rdw_r      <= i2csp_pkg::WORD_RESET;
			oe_r       <= 1'b0;
			hs_r       <= 1'b0;
			never_lo_r <= 1'b1;
			never_hi_r <= 1'b1;
			eq_scl_r   <= 1'b1;
			wrw_r      <= '0;
			ev_r       <= '0;
		end else begin
			st_r       <= st_nxt;
			scl_d_r    <= scl_d_nxt;
			sda_d_r    <= sda_d_nxt;
			back_d_r   <= back_d_nxt;
			cnt_r      <= cnt_nxt;
			sh_r       <= sh_nxt;
			first_r    <= first_nxt;
			rw_r       <= rw_nxt;
			gc_r       <= gc_nxt;
			idx_r      <= idx_nxt;
			txidx_r    <= txidx_nxt;
			ptr_r      <= ptr_nxt;
			hi_r       <= hi_nxt;
			rdw_r      <= rdw_nxt;
			oe_r       <= oe_nxt;
			hs_r       <= hs_nxt;
			never_lo_r <= never_lo_nxt;
			never_hi_r <= never_hi_nxt;
			eq_scl_r   <= eq_scl_nxt;
			wrw_r      <= wrw_nxt;
			ev_r       <= ev_nxt;
		end
	end

	// open drain: data only ever pulled low, clock never driven [RQ1] [RQ2]
	assign sda_o    = 1'b0;
	assign sda_oe_o = oe_r;
	assign scl_o    = 1'b0;
	assign scl_oe_o = 1'b0;

	// ---------------- core domain ----------------
	// toggles cross on two flops; words stay put in the source until their toggle is seen
	i2csp_pkg::i2csp_ev_t ev_s;
	logic [6:0] ev_v;
	logic       expire;

	i2csp_sync #(.W(7)) u_ev_sync (
		.clk_i    (mclk_i),
		.resetn_i (resetn_i),
		.d_i      (ev_r),
		.q_o      (ev_v)
	);
	assign ev_s = ev_v;

	logic                 tg_d_r[5];
	logic [4:0]           tg_d_nxt;
	logic [4:0]           tg_d_v;
	logic                 wr_stb_r, wr_stb_nxt, gc_rst_r, gc_rst_nxt, hs_m_r, hs_m_nxt;
	logic                 snap_tg_nxt, abort_tg_nxt;
	logic [15:0]          snap_nxt;
	logic [2:0]           ptr_m_nxt;
	i2csp_pkg::i2csp_wr_t wr_m_r, wr_m_nxt;
	logic                 act_c;

	i2csp_timeout #(.LIMIT(TIMEOUT_CYC)) u_timeout (
		.clk_i    (mclk_i),
		.resetn_i (resetn_i),
		.busy_i   (ev_s.busy),
		.act_i    (act_c),
		.expire_o (expire)
	);

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_tg
			assign tg_d_v[gi] = tg_d_r[gi];
		end
	endgenerate

	always_comb begin
		tg_d_nxt     = {ev_s.wr, ev_s.ptr, ev_s.gc, ev_s.req, ev_s.act};
		act_c        = ev_s.act ^ tg_d_v[0];
		wr_stb_nxt   = ev_s.wr ^ tg_d_v[4];                               // [RQ15]
		wr_m_nxt     = wr_stb_nxt ? wrw_r : wr_m_r;
		ptr_m_nxt    = (ev_s.ptr ^ tg_d_v[3]) ? ptr_r : ptr_m_r;          // [RQ19]
		gc_rst_nxt   = ev_s.gc ^ tg_d_v[2];                               // [RQ10]
		snap_tg_nxt  = snap_tg_r ^ (ev_s.req ^ tg_d_v[1]);
		snap_nxt     = (ev_s.req ^ tg_d_v[1]) ? rd_data_i : snap_r;       // [RQ16]
		abort_tg_nxt = abort_tg_r ^ expire;                               // [RQ5]
		hs_m_nxt     = ev_s.hs;                                           // [RQ11] [RQ12]
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < 5; i++)
				tg_d_r[i] <= 1'b0;
			wr_stb_r   <= 1'b0;
			wr_m_r     <= '0;
			ptr_m_r    <= i2csp_pkg::PTR_RESET;
			gc_rst_r   <= 1'b0;
			snap_tg_r  <= 1'b0;
			snap_r     <= i2csp_pkg::WORD_RESET;
			abort_tg_r <= 1'b0;
			hs_m_r     <= 1'b0;
		end else begin
			for (int i = 0; i < 5; i++)
				tg_d_r[i] <= tg_d_nxt[i];
			wr_stb_r   <= wr_stb_nxt;
			wr_m_r     <= wr_m_nxt;
			ptr_m_r    <= ptr_m_nxt;
			gc_rst_r   <= gc_rst_nxt;
			snap_tg_r  <= snap_tg_nxt;
			snap_r     <= snap_nxt;
			abort_tg_r <= abort_tg_nxt;
			hs_m_r     <= hs_m_nxt;
		end
	end

	assign rd_ptr_o   = ptr_m_r;
	assign wr_stb_o   = wr_stb_r;
	assign wr_ptr_o   = wr_m_r.ptr;
	assign wr_data_o  = wr_m_r.data;
	assign gc_reset_o = gc_rst_r;
	assign hs_mode_o  = hs_m_r;
endmodule

// ===== testbench/i2csp_top_sva.sv
// concurrent checks on the pins of the two-wire slave register port
`timescale 1ns/1ns
module i2csp_top_sva #(
	parameter int TIMEOUT_CYC = 2000
) (
	input wire logic        mclk_i,
	input wire logic        resetn_i,
	input wire logic        link_clk_i,
	input wire logic        scl_i,
	input wire logic        scl_oe_o,
	input wire logic        sda_i,
	input wire logic        sda_o,
	input wire logic        sda_oe_o,
	input wire logic        wr_stb_o,
	input wire logic [2:0]  wr_ptr_o,
	input wire logic [15:0] wr_data_o,
	input wire logic        gc_reset_o,
	input wire logic        hs_mode_o
);
	// pins are sampled raw on the link clock; the master moves them between its edges
	sequence stop_cond;
		scl_i && $past(scl_i) && $rose(sda_i);
	endsequence

	// core cycles since the clock line last moved; margin covers both crossings
	int   quiet_r;
	logic scl_q_r;
	always @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			quiet_r <= 0;
			scl_q_r <= 1'b1;
		end else begin
			scl_q_r <= scl_i;
			quiet_r <= (scl_i != scl_q_r) ? 0 : quiet_r + 1;
		end
	end

	chk_tmo_release: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		quiet_r > TIMEOUT_CYC + 64 |-> !sda_oe_o) else $error("data held past bus timeout");

	chk_scl_free: assert property (@(posedge link_clk_i) disable iff (!resetn_i) !scl_oe_o)
		else $error("clock line driven");
	chk_sda_lowonly: assert property (@(posedge link_clk_i) disable iff (!resetn_i) sda_oe_o |-> !sda_o)
		else $error("data line driven high");
	chk_oe_hold: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
		scl_i && $past(scl_i) |-> $stable(sda_oe_o)) else $error("data drive moved while clock high");
	chk_stop_idle: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
		stop_cond |-> !sda_oe_o [*8]) else $error("data driven after stop");
	chk_hs_exit: assert property (@(posedge link_clk_i) disable iff (!resetn_i)
		stop_cond |-> ##[1:16] !hs_mode_o) else $error("high speed mode kept after stop");
	chk_wr_pulse: assert property (@(posedge mclk_i) disable iff (!resetn_i) wr_stb_o |=> !wr_stb_o)
		else $error("write strobe longer than one cycle");
	chk_gc_pulse: assert property (@(posedge mclk_i) disable iff (!resetn_i) gc_reset_o |=> !gc_reset_o)
		else $error("general call reset longer than one cycle");
	chk_wr_hold: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		$changed({wr_ptr_o, wr_data_o}) |-> wr_stb_o) else $error("write word moved without strobe");

	cov_write: cover property (@(posedge mclk_i) disable iff (!resetn_i) wr_stb_o);
	cov_gcall: cover property (@(posedge mclk_i) disable iff (!resetn_i) gc_reset_o);
	cov_hs: cover property (@(posedge mclk_i) disable iff (!resetn_i) $rose(hs_mode_o));
endmodule

bind i2csp_top i2csp_top_sva #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_sva (
	.mclk_i(mclk_i), .resetn_i(resetn_i), .link_clk_i(link_clk_i), .scl_i(scl_i), .scl_oe_o(scl_oe_o),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wr_stb_o(wr_stb_o), .wr_ptr_o(wr_ptr_o),
	.wr_data_o(wr_data_o), .gc_reset_o(gc_reset_o), .hs_mode_o(hs_mode_o));

// ===== testbench/i2csp_bus_master.sv
// bus master model: open-drain clock and data pull-downs with bit and byte tasks
`timescale 1ns/1ns
module i2csp_bus_master #(
	parameter int H = 6
) (
	input  wire logic lclk_i,
	input  wire logic sda_i,
	output logic      scl_lo_o,
	output logic      sda_lo_o
);
	initial begin
		scl_lo_o = 1'b0;
		sda_lo_o = 1'b0;
	end
	// moves on falling link edges so the port never samples a changing pin
	task automatic tk(input int n);
		repeat (n) @(negedge lclk_i);
	endtask
	task automatic start();
		sda_lo_o = 1'b0;
		tk(H);
		scl_lo_o = 1'b0;
		tk(H);
		sda_lo_o = 1'b1;
		tk(H);
		scl_lo_o = 1'b1;
		tk(H);
	endtask
	task automatic stop();
		sda_lo_o = 1'b1;
		tk(H);
		scl_lo_o = 1'b0;
		tk(H);
		sda_lo_o = 1'b0;
		tk(H);
	endtask
	// data set with clock low, read back mid high phase
	task automatic bitx(input logic b, output logic r);
		sda_lo_o = !b;
		tk(H);
		scl_lo_o = 1'b0;
		tk(H / 2);
		r = sda_i;
		tk(H - H / 2);
		scl_lo_o = 1'b1;
		tk(1);
	endtask
	task automatic wbyte(input logic [7:0] d, output logic nak);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r);
		end
		bitx(1'b1, nak);
	endtask
	task automatic rbyte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, d[i]);
		end
		bitx(!ack, r);
	endtask
endmodule

// ===== testbench/testbench.sv
// self-checking bench for the two-wire slave register port
`timescale 1ns/1ns
module testbench;
	localparam int TMO = 2000;
	logic        mclk, lclk, rstn, scl_lo, sda_lo, scl_o, scl_oe, sda_o, sda_oe;
	logic [1:0]  asel;
	logic        wr_stb, gc_rst, hs;
	logic [2:0]  rd_ptr, wr_ptr;
	logic [15:0] wr_data;
	logic [15:0] regs [8];
	int          err_total, n_checks, cyc, n_wr, n_gc;
	wire         scl_w = !(scl_lo | scl_oe);
	wire         sda_w = !(sda_lo | sda_oe);
	// address pin tie: 0 ground, 1 supply, 2 data wire, 3 clock wire
	wire         apin  = asel[1] ? (asel[0] ? scl_w : sda_w) : asel[0];

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		lclk = 1'b0;
		#7;
		forever #40 lclk = ~lclk;
	end

	i2csp_top #(.TIMEOUT_CYC(TMO)) dut (
		.mclk_i(mclk), .resetn_i(rstn), .link_clk_i(lclk), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_pin_i(apin), .rd_data_i(regs[rd_ptr]),
		.rd_ptr_o(rd_ptr), .wr_stb_o(wr_stb), .wr_ptr_o(wr_ptr), .wr_data_o(wr_data), .gc_reset_o(gc_rst),
		.hs_mode_o(hs));
	i2csp_bus_master m (.lclk_i(lclk), .sda_i(sda_w), .scl_lo_o(scl_lo), .sda_lo_o(sda_lo));

	always @(negedge mclk) begin
		cyc++;
		if (wr_stb === 1'b1) n_wr++;
		if (gc_rst === 1'b1) n_gc++;
		if (cyc == 60000) begin
			err_total++;
			close_out();
		end
	end

	task automatic close_out();
		if (err_total == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk_bit(input string n, input logic e, input logic g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic addr(input logic [7:0] a, input logic e);
		logic nk;
		m.wbyte(a, nk);
		chk_bit("ack", e, nk);
	endtask
	task automatic rd2(output logic [15:0] v);
		m.rbyte(1'b1, v[15:8]);
		m.rbyte(1'b0, v[7:0]);
	endtask

	task automatic t_write();
		m.start();
		addr(8'h90, 1'b0);
		addr(8'h03, 1'b0);
		addr(8'hA5, 1'b0);
		addr(8'h3C, 1'b0);
		addr(8'h77, 1'b1);
		m.stop();
		chk_word("writes", 16'h0001, 16'(n_wr));
		chk_word("wr data", 16'hA53C, wr_data);
		chk_word("wr ptr", 16'h0003, {13'h0, wr_ptr});
		chk_word("rd ptr", 16'h0003, {13'h0, rd_ptr});
		chk_bit("scl out", 1'b0, scl_o);
	endtask
	task automatic t_rlen();
		logic [15:0] v;
		logic [7:0]  x;
		m.start();
		addr(8'h91, 1'b0);
		m.rbyte(1'b0, v[15:8]);
		m.stop();
		chk_word("one byte", {8'h00, regs[5][15:8]}, {8'h00, v[15:8]});
		m.start();
		addr(8'h91, 1'b0);
		m.rbyte(1'b1, v[15:8]);
		m.rbyte(1'b1, v[7:0]);
		m.rbyte(1'b0, x);
		m.stop();
		chk_word("ack lo", regs[5], v);
		chk_word("extra byte", 16'h00FF, {8'h00, x});
		chk_bit("rlen release", 1'b0, sda_oe);
	endtask
	task automatic t_read(input int p);
		logic [15:0] v;
		m.start();
		addr(8'h91, 1'b0);
		rd2(v);
		m.stop();
		chk_word("rd word", regs[p], v);
		chk_bit("rd release", 1'b0, sda_oe);
	endtask
	task automatic t_rstart();
		logic [15:0] v;
		m.start();
		addr(8'h90, 1'b0);
		addr(8'h05, 1'b0);
		m.start();
		addr(8'h91, 1'b0);
		rd2(v);
		m.stop();
		chk_word("rs word", regs[5], v);
		chk_word("ptr only", 16'h0001, 16'(n_wr));
	endtask
	task automatic t_tmo();
		m.start();
		addr(8'h91, 1'b0);
		m.tk(8);
		chk_bit("tx drive", 1'b1, sda_oe);
		repeat (TMO + 100) @(negedge mclk);
		chk_bit("tmo release", 1'b0, sda_oe);
		m.stop();
		t_read(5);
	endtask
	task automatic t_addr();
		for (int s = 0; s < 4; s++) begin
			@(negedge mclk) asel = 2'(s);
			for (int i = 0; i < 4; i++) begin
				m.start();
				addr({5'h12, i[1:0], 1'b0}, i != s);
				m.stop();
				chk_bit("idle", 1'b0, sda_oe);
			end
		end
		@(negedge mclk) asel = 2'h0;
	endtask
	task automatic t_gcall();
		m.start();
		addr(8'h00, 1'b0);
		addr(8'h06, 1'b0);
		m.stop();
		m.start();
		addr(8'h00, 1'b0);
		addr(8'h04, 1'b0);
		addr(8'h06, 1'b1);
		m.stop();
		m.start();
		addr(8'h01, 1'b1);
		m.stop();
		chk_word("gc pulses", 16'h0001, 16'(n_gc));
	endtask
	task automatic t_hs();
		m.start();
		addr(8'h0D, 1'b1);
		repeat (10) @(negedge mclk);
		chk_bit("hs on", 1'b1, hs);
		m.stop();
		chk_bit("hs off", 1'b0, hs);
	endtask

	initial begin
		rstn = 1'b0;
		asel = 2'h0;
		err_total = 0;
		n_checks = 0;
		cyc = 0;
		n_wr = 0;
		n_gc = 0;
		for (int i = 0; i < 8; i++) regs[i] = 16'hC3A0 + 16'(i);
		// high byte msb low so the port pulls data at the start of a read
		regs[5] = 16'h2A55;
		// reset spans two rising edges of the slower link clock so both domains see it
		repeat (2) @(posedge lclk);
		@(negedge mclk) rstn = 1'b1;
		repeat (4) @(posedge lclk);
		t_write();
		t_read(3);
		t_read(3);
		t_rstart();
		t_tmo();
		t_rlen();
		t_addr();
		t_gcall();
		t_hs();
		close_out();
	end
endmodule
